// file: hw/opsc_pkg.sv
package opsc_pkg;
   // ****************************************
   // panel register map
   // ****************************************
   localparam logic [2:0] OFF_MSG  = 3'h0;
   localparam logic [2:0] OFF_DATA = 3'h2;
   localparam logic [2:0] OFF_STAT = 3'h6;
   localparam logic [2:0] OFF_CTRL = 3'h7;

   // status word fields
   localparam int ST_BTN   = 0;
   localparam int ST_READY = 5;
   localparam int ST_ENTER = 9;
   localparam int ST_UP    = 10;
   localparam int ST_DOWN  = 11;

   // control word fields
   localparam int CT_LAMP  = 0;
   localparam int CT_BLINK = 3;
   localparam int CT_ACK   = 6;
   localparam int CT_MUTE  = 9;

   localparam logic [15:0] CTRL_RESET  = 16'h0000;
   localparam logic [15:0] VALUE_MAX   = 16'hffff;
   localparam logic [1:0]  PARITY_NONE = 2'h0;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_HZ         = 100_000_000;
   localparam int BLINK_HALF_MS  = 250;
   localparam int BLINK_HALF_CYC = BLINK_HALF_MS * (CLK_HZ / 1000);

   // ****************************************
   // controller register map (byte addresses)
   // ****************************************
   localparam logic [7:0] H_TARGET = 8'h00;
   localparam logic [7:0] H_WDATA  = 8'h04;
   localparam logic [7:0] H_CMD    = 8'h08;
   localparam logic [7:0] H_AUTO   = 8'h0c;
   localparam logic [7:0] H_CTRL   = 8'h10;
   localparam logic [7:0] H_STAT   = 8'h14;
   localparam logic [7:0] H_RDATA  = 8'h18;
   localparam logic [7:0] H_LIVE   = 8'h1c;
   localparam logic [7:0] H_FINAL  = 8'h20;
   localparam int CMD_WE = 8;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// file: hw/opsc_link_if.sv
`timescale 1ns/10ps
interface opsc_link_if;
   logic        req;
   logic        we;
   logic [4:0]  mod_addr;
   logic [2:0]  off;
   logic [15:0] wdata;
   logic        ack;
   logic [15:0] rdata;

   modport dev (
      input  req,
      input  we,
      input  mod_addr,
      input  off,
      input  wdata,
      output ack,
      output rdata
   );
   modport host (
      output req,
      output we,
      output mod_addr,
      output off,
      output wdata,
      input  ack,
      input  rdata
   );
endinterface

// file: hw/opsc_panel_dev.sv
// Behaviour
// - enter press sets entry ready flag
// - acknowledge bit seen clears entry ready flag
// - host copies value, then sets acknowledge
// - status at offset 6, control at 7
// - status bit positions for buttons, keys
// - control bit positions lamps, blink, ack, mute
// - lamp lit steadily while enable set and blink clear
// - blink needs enable and blink bits
// - button states always shown in status
// - host copies setpoint until ready flag
// - module address 0 to 31 from switches
// - host initiates every access, device answers
// - framing configurable, parity forces one stop
// - ready flag held until message or ack
// - buttons alternate-action or momentary each
// - mute bit silences the buzzer
`timescale 1ns/10ps
module opsc_panel_dev
   import opsc_pkg::*;
#(
   parameter int BLINK_CYC = BLINK_HALF_CYC
)(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   opsc_link_if.dev         link,
   input  wire logic [4:0]  addr_sw,
   input  wire logic [4:0]  btn_raw,
   input  wire logic [4:0]  btn_alt,
   input  wire logic        key_digit_stb,
   input  wire logic [3:0]  key_digit,
   input  wire logic        key_enter,
   input  wire logic        key_up,
   input  wire logic        key_down,
   input  wire logic [2:0]  cfg_baud,
   input  wire logic [1:0]  cfg_parity,
   input  wire logic        cfg_two_stop,
   output logic      [2:0]  lamp,
   output logic             buzzer,
   output logic      [2:0]  frame_baud,
   output logic      [1:0]  frame_parity,
   output logic             frame_two_stop
);
   // ****************************************
   // state
   // ****************************************
   logic [4:0]  my_addr;
   logic [4:0]  btn_q;
   logic [4:0]  btn_state;
   logic        enter_q;
   logic        up_q;
   logic        down_q;
   logic        entry_ready_flag;
   logic        fresh;
   logic [15:0] value;
   logic [15:0] msg_sel;
   logic [15:0] ctrl;
   logic [15:0] status;
   logic        ack_q;
   logic [31:0] blink_cnt;
   logic        blink_phase;
   logic        hit;
   logic        wr;
   logic        enter_rise;
   logic        up_rise;
   logic        down_rise;
   logic [19:0] acc;

   // ****************************************
   // link slave
   // ****************************************
   // switch address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         my_addr <= 5'h00;
      end else begin
         my_addr <= addr_sw;
      end
   end

   assign hit = link.req && (link.mod_addr == my_addr) && !ack_q;
   assign wr  = hit && link.we;
   assign link.ack = ack_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= hit;
      end
   end

   always_comb begin
      status = 16'h0000;
      status[ST_BTN +: 5] = btn_state;
      status[ST_READY]    = entry_ready_flag;
      status[ST_ENTER]    = key_enter;
      status[ST_UP]       = key_up;
      status[ST_DOWN]     = key_down;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         link.rdata <= 16'h0000;
      end else if (hit && !link.we) begin
         case (link.off)
            OFF_MSG:  link.rdata <= msg_sel;
            OFF_DATA: link.rdata <= value;
            OFF_STAT: link.rdata <= status;
            OFF_CTRL: link.rdata <= ctrl;
            default:  link.rdata <= 16'h0000;
         endcase
      end
   end

   // control word stored whole, fields used below
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl    <= CTRL_RESET;
         msg_sel <= 16'h0000;
      end else if (wr && link.off == OFF_CTRL) begin
         ctrl <= link.wdata;
      end else if (wr && link.off == OFF_MSG) begin
         msg_sel <= link.wdata;
      end
   end

   // ****************************************
   // keys and buttons
   // ****************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         btn_q   <= 5'h00;
         enter_q <= 1'b0;
         up_q    <= 1'b0;
         down_q  <= 1'b0;
      end else begin
         btn_q   <= btn_raw;
         enter_q <= key_enter;
         up_q    <= key_up;
         down_q  <= key_down;
      end
   end

   assign enter_rise = key_enter && !enter_q;
   assign up_rise    = key_up && !up_q;
   assign down_rise  = key_down && !down_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         btn_state <= 5'h00;
      end else begin
         for (int i = 0; i < 5; i++) begin
            if (!btn_alt[i]) begin
               btn_state[i] <= btn_raw[i];
            end else if (btn_raw[i] && !btn_q[i]) begin
               btn_state[i] <= !btn_state[i];
            end
         end
      end
   end

   // decimal shift-in, clipped to the 16-bit range
   assign acc = {4'h0, value} * 20'd10 + {16'h0000, key_digit};

   // host write wins over the keypad; a new message restarts entry
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         value <= 16'h0000;
         fresh <= 1'b1;
      end else if (wr && link.off == OFF_DATA) begin
         value <= link.wdata;
         fresh <= 1'b0;
      end else if (wr && link.off == OFF_MSG) begin
         fresh <= 1'b1;
      end else if (key_digit_stb) begin
         fresh <= 1'b0;
         if (fresh) begin
            value <= {12'h000, key_digit};
         end else if (acc > {4'h0, VALUE_MAX}) begin
            value <= VALUE_MAX;
         end else begin
            value <= acc[15:0];
         end
      end else if (up_rise && value != VALUE_MAX) begin
         value <= value + 16'h0001;
      end else if (down_rise && value != 16'h0000) begin
         value <= value - 16'h0001;
      end
   end

   // set on enter; set wins over a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         entry_ready_flag <= 1'b0;
      end else if (enter_rise) begin
         entry_ready_flag <= 1'b1;
      end else if (ctrl[CT_ACK]) begin
         entry_ready_flag <= 1'b0;
      end else if (wr && link.off == OFF_MSG) begin
         entry_ready_flag <= 1'b0;
      end
   end

   // ****************************************
   // lamps and buzzer
   // ****************************************
   // fixed half period
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         blink_cnt   <= 32'h00000000;
         blink_phase <= 1'b0;
      end else if (blink_cnt >= 32'(BLINK_CYC - 1)) begin
         blink_cnt   <= 32'h00000000;
         blink_phase <= !blink_phase;
      end else begin
         blink_cnt <= blink_cnt + 32'h00000001;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lamp <= 3'h0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            // steady or blinking, only when enabled
            lamp[i] <= ctrl[CT_LAMP + i]
                       && (!ctrl[CT_BLINK + i] || blink_phase);
         end
      end
   end

   // sounds while any key is held, a click per press
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         buzzer <= 1'b0;
      end else begin
         buzzer <= (|btn_raw || key_enter || key_up || key_down
                    || key_digit_stb) && !ctrl[CT_MUTE];
      end
   end

   // ****************************************
   // serial framing
   // ****************************************
   // parity forces a single stop bit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         frame_baud     <= 3'h0;
         frame_parity   <= PARITY_NONE;
         frame_two_stop <= 1'b0;
      end else begin
         frame_baud     <= cfg_baud;
         frame_parity   <= cfg_parity;
         frame_two_stop <= cfg_two_stop && (cfg_parity == PARITY_NONE);
      end
   end
endmodule

// file: hw/opsc_panel_host.sv
`timescale 1ns/10ps
module opsc_panel_host
   import opsc_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   opsc_link_if.host        link,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic      [1:0]  s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic      [31:0] s_axi_rdata,
   output logic      [1:0]  s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   typedef enum logic [1:0] {
      S_IDLE = 2'b01,
      S_REQ  = 2'b10
   } opsc_state_t;

   opsc_state_t state;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic        aw_full;
   logic        w_full;
   logic        do_wr;
   logic        wr_hit;
   logic [4:0]  target;
   logic [15:0] man_wdata;
   logic [15:0] ctrl_shadow;
   logic        auto_en;
   logic        cmd_pend;
   logic        cmd_we;
   logic [2:0]  cmd_off;
   logic        done;
   logic        seen_ready;
   logic        final_new;
   logic [15:0] last_rdata;
   logic [15:0] live_value;
   logic [15:0] final_value;
   logic [1:0]  step;
   logic        op_auto;
   logic        busy;

   // ****************************************
   // axi4-lite write side
   // ****************************************
   assign s_axi_awready = !aw_full;
   assign s_axi_wready  = !w_full;
   assign do_wr = aw_full && w_full && !s_axi_bvalid;
   assign busy  = (state == S_REQ) || cmd_pend;
   assign wr_hit = (aw_addr == H_TARGET) || (aw_addr == H_WDATA)
                   || (aw_addr == H_CMD) || (aw_addr == H_AUTO)
                   || (aw_addr == H_CTRL);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         w_full  <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 32'h00000000;
      end else begin
         if (s_axi_awvalid && !aw_full) begin
            aw_full <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (do_wr) begin
            aw_full <= 1'b0;
         end
         if (s_axi_wvalid && !w_full) begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
         end else if (do_wr) begin
            w_full <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (do_wr) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // byte strobes ignored: every register is written whole
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         target      <= 5'h00;
         man_wdata   <= 16'h0000;
         auto_en     <= 1'b0;
         ctrl_shadow <= CTRL_RESET;
      end else if (do_wr) begin
         case (aw_addr)
            H_TARGET: target      <= w_data[4:0];
            H_WDATA:  man_wdata   <= w_data[15:0];
            H_AUTO:   auto_en     <= w_data[0];
            H_CTRL:   ctrl_shadow <= w_data[15:0];
            default:  ;
         endcase
      end
   end

   // a command while busy is dropped, not queued
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_pend <= 1'b0;
         cmd_we   <= 1'b0;
         cmd_off  <= 3'h0;
      end else if (do_wr && aw_addr == H_CMD && !busy) begin
         cmd_pend <= 1'b1;
         cmd_we   <= w_data[CMD_WE];
         cmd_off  <= w_data[2:0];
      end else if (state == S_IDLE) begin
         cmd_pend <= 1'b0;
      end
   end

   // ****************************************
   // axi4-lite read side
   // ****************************************
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= RESP_OKAY;
         case (s_axi_araddr)
            H_TARGET: s_axi_rdata <= {27'h0, target};
            H_WDATA:  s_axi_rdata <= {16'h0, man_wdata};
            H_CMD:    s_axi_rdata <= 32'h00000000;
            H_AUTO:   s_axi_rdata <= {31'h0, auto_en};
            H_CTRL:   s_axi_rdata <= {16'h0, ctrl_shadow};
            H_STAT:   s_axi_rdata <= {28'h0, final_new, seen_ready,
                                      done, busy};
            H_RDATA:  s_axi_rdata <= {16'h0, last_rdata};
            H_LIVE:   s_axi_rdata <= {16'h0, live_value};
            H_FINAL:  s_axi_rdata <= {16'h0, final_value};
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= RESP_DECERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ****************************************
   // link master
   // ****************************************
   assign link.mod_addr = target;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state      <= S_IDLE;
         link.req   <= 1'b0;
         link.we    <= 1'b0;
         link.off   <= 3'h0;
         link.wdata <= 16'h0000;
         op_auto    <= 1'b0;
      end else begin
         case (state)
            S_IDLE: begin
               if (cmd_pend) begin
                  state      <= S_REQ;
                  link.req   <= 1'b1;
                  link.we    <= cmd_we;
                  link.off   <= cmd_off;
                  link.wdata <= man_wdata;
                  op_auto    <= 1'b0;
               end else if (auto_en) begin
                  state    <= S_REQ;
                  link.req <= 1'b1;
                  op_auto  <= 1'b1;
                  link.we  <= step[1];
                  link.off <= step[1] ? OFF_CTRL
                            : (step[0] ? OFF_DATA : OFF_STAT);
                  // ack set on step 2, released on step 3
                  link.wdata <= step[0] ? ctrl_shadow
                              : (ctrl_shadow | (16'h0001 << CT_ACK));
               end
            end
            S_REQ: begin
               if (link.ack) begin
                  state    <= S_IDLE;
                  link.req <= 1'b0;
               end
            end
            default: begin
               state    <= S_IDLE;
               link.req <= 1'b0;
            end
         endcase
      end
   end

   // auto loop: poll status, fetch value, ack when the flag is up
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         step        <= 2'h0;
         seen_ready  <= 1'b0;
         last_rdata  <= 16'h0000;
         live_value  <= 16'h0000;
         final_value <= 16'h0000;
      end else if (state == S_REQ && link.ack) begin
         if (!link.we) begin
            last_rdata <= link.rdata;
         end
         if (op_auto) begin
            case (step)
               2'h0: begin
                  seen_ready <= link.rdata[ST_READY];
                  step       <= 2'h1;
               end
               2'h1: begin
                  if (seen_ready) begin
                     final_value <= link.rdata;
                     step        <= 2'h2;
                  end else begin
                     live_value <= link.rdata;
                     step       <= 2'h0;
                  end
               end
               2'h2:    step <= 2'h3;
               default: step <= 2'h0;
            endcase
         end
      end
   end

   // sticky flags; a new event wins over the clearing access
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         done      <= 1'b0;
         final_new <= 1'b0;
      end else begin
         if (state == S_REQ && link.ack && !op_auto) begin
            done <= 1'b1;
         end else if (do_wr && aw_addr == H_CMD && !busy) begin
            done <= 1'b0;
         end
         if (state == S_REQ && link.ack && op_auto
             && step == 2'h1 && seen_ready) begin
            final_new <= 1'b1;
         end else if (s_axi_arvalid && !s_axi_rvalid
                      && s_axi_araddr == H_FINAL) begin
            final_new <= 1'b0;
         end
      end
   end
endmodule

// file: tb/opsc_link_sva.sv
`timescale 1ns/10ps
module opsc_link_sva
   import opsc_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        req,
   input wire logic        we,
   input wire logic [4:0]  mod_addr,
   input wire logic [2:0]  off,
   input wire logic [15:0] wdata,
   input wire logic        ack,
   input wire logic [15:0] rdata
);
   // ****************
   // link checks
   // ****************
   default clocking dc @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // control word as last written, to judge readback and flag clearing
   logic [15:0] ctl;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctl <= CTRL_RESET;
      end else if (ack && we && off == OFF_CTRL) begin
         ctl <= wdata;
      end
   end

   sequence s_start;
      $rose(req);
   endsequence
   sequence s_answer;
      ##1 ack ##1 !req;
   endsequence

   a_access_answered: assert property (s_start |-> s_answer)
      else $error("link request not answered in one cycle");
   a_ack_pulse: assert property (ack |=> !ack)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (ack |-> $past(req))
      else $error("ack without request");
   a_req_held: assert property (req && !ack |=>
      req && $stable({we, off, wdata}))
      else $error("request changed before ack");
   a_rdata_hold: assert property (!ack |-> $stable(rdata))
      else $error("read data moved without ack");
   a_stat_layout: assert property (ack && !we && off == OFF_STAT
      |-> rdata[15:12] == 4'h0 && rdata[8:6] == 3'h0)
      else $error("status word has stray bits");
   a_ctrl_readback: assert property (ack && !we && off == OFF_CTRL
      |-> rdata[9] == ctl[9] && rdata[6:0] == ctl[6:0])
      else $error("control word readback differs");
   a_flag_cleared: assert property (ack && !we && off == OFF_STAT
      && ctl[CT_ACK] |-> !rdata[ST_READY])
      else $error("ready flag set while ack bit set");
endmodule

// file: tb/operator_panel_status_control_tb.sv
`timescale 1ns/10ps
module operator_panel_status_control_tb
   import opsc_pkg::*;
;
   // ****************
   // bench
   // ****************
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [1:0]  bresp, rresp, cp, fp;
   logic [4:0]  asw, btn, alt;
   logic [3:0]  dig;
   logic        dstb, ken, kup, kdn, c2, buzzer, f2;
   logic [2:0]  cb, lamp, fb;
   logic [15:0] q;
   int          compares = 0;
   int          mismatches = 0;

   opsc_link_if lk ();
   opsc_panel_dev #(.BLINK_CYC(8)) i_opsc_panel_dev (
      .aclk(aclk), .aresetn(aresetn), .link(lk.dev), .addr_sw(asw),
      .btn_raw(btn), .btn_alt(alt), .key_digit_stb(dstb), .key_digit(dig),
      .key_enter(ken), .key_up(kup), .key_down(kdn), .cfg_baud(cb),
      .cfg_parity(cp), .cfg_two_stop(c2), .lamp(lamp), .buzzer(buzzer),
      .frame_baud(fb), .frame_parity(fp), .frame_two_stop(f2));
   opsc_panel_host i_opsc_panel_host (
      .aclk(aclk), .aresetn(aresetn), .link(lk.host),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   opsc_link_sva i_sva (.aclk(aclk), .aresetn(aresetn), .req(lk.req),
      .we(lk.we), .mod_addr(lk.mod_addr), .off(lk.off),
      .wdata(lk.wdata), .ack(lk.ack), .rdata(lk.rdata));

   always #5 aclk = ~aclk;

   task wrap_up;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask
   task tmo(input logic ok);
      if (!ok) begin
         mismatches++;
         $display("MISMATCH %0t wait ran out", $time);
         wrap_up;
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   // handshakes judged at the falling edge: ready cannot move before the
   // next rising edge, so that edge is the one that takes the item
   task axi_wr(input logic [7:0] a, input logic [31:0] v,
               input logic [1:0] e);
      int         n;
      logic       ta, tw, tb;
      logic [1:0] r;
      n = 0;
      tb = 1'b0;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!tb && n < 300) begin
         @(negedge aclk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         tb = bvalid;
         r = bresp;
         n++;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end
      // bready stays up between calls: a back-to-back call would
      // otherwise lower and raise it in one time step
      tmo(tb);
      chk(32'(r), 32'(e));
   endtask
   task axi_rd(input logic [7:0] a, input logic [1:0] e);
      int         n;
      logic       ta, tr;
      logic [1:0] r;
      n = 0;
      tr = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!tr && n < 300) begin
         @(negedge aclk);
         ta = arvalid & arready;
         tr = rvalid;
         d = rdata;
         r = rresp;
         n++;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
      end
      // rready stays up between calls, for the same reason as bready
      tmo(tr);
      chk(32'(r), 32'(e));
   endtask
   task rdchk(input logic [7:0] a, input logic [31:0] e);
      axi_rd(a, RESP_OKAY);
      chk(d, e);
   endtask
   // one link access through the controller's command register
   task lnk(input logic w, input logic [2:0] o, input logic [15:0] v);
      int n;
      n = 0;
      axi_wr(H_WDATA, {16'h0, v}, RESP_OKAY);
      axi_wr(H_CMD, {23'h0, w, 5'h0, o}, RESP_OKAY);
      d = 32'h0;
      while (d[1] !== 1'b1 && n < 50) begin
         axi_rd(H_STAT, RESP_OKAY);
         n++;
      end
      tmo(d[1] === 1'b1);
      axi_rd(H_RDATA, RESP_OKAY);
      q = d[15:0];
   endtask
   task lr(input logic [2:0] o, input logic [15:0] e);
      lnk(1'b0, o, 16'h0);
      chk(32'(q), 32'(e));
   endtask
   task dg(input logic [3:0] v);
      dig <= v;
      dstb <= 1'b1;
      cyc(1);
      dstb <= 1'b0;
      cyc(2);
   endtask
   task enter;
      ken <= 1'b1;
      cyc(2);
      ken <= 1'b0;
      cyc(2);
   endtask
   task lamps(input logic [15:0] c, input int e0, e1, e2);
      int k[3];
      k = '{0, 0, 0};
      lnk(1'b1, OFF_CTRL, c);
      cyc(3);
      repeat (32) begin
         @(negedge aclk);
         foreach (k[i]) k[i] += int'(lamp[i]);
      end
      @(posedge aclk);
      chk(k[0], e0);
      chk(k[1], e1);
      chk(k[2], e2);
   endtask

   initial begin
      {awaddr, wdata, awvalid, wvalid, bready} = '0;
      {araddr, arvalid, rready, btn, dig, dstb, ken, kup, kdn} = '0;
      asw = 5'h1f;
      alt = 5'h02;
      {cb, cp, c2} = {3'h5, 2'h1, 1'b1};
      cyc(6);
      aresetn <= 1'b1;
      cyc(1);
      chk(32'({lamp, buzzer}), 32'h0);
      rdchk(H_STAT, 32'h0);
      axi_rd(8'h40, RESP_DECERR);
      chk(d, 32'h0);
      axi_wr(H_STAT, 32'h1, RESP_DECERR);
      axi_wr(H_TARGET, 32'h1f, RESP_OKAY);
      rdchk(H_TARGET, 32'h1f);
      chk(32'({fb, fp, f2}), 32'h2a);
      cp <= 2'h0;
      cyc(3);
      chk(32'({fb, fp, f2}), 32'h29);
      lr(OFF_CTRL, CTRL_RESET);
      btn <= 5'h17;
      cyc(3);
      chk(32'(buzzer), 32'h1);
      btn <= 5'h15;
      cyc(3);
      lr(OFF_STAT, 16'h0017);
      lnk(1'b1, OFF_CTRL, 16'h0200);
      chk(32'(buzzer), 32'h0);
      btn <= 5'h17;
      cyc(3);
      btn <= 5'h00;
      cyc(3);
      lr(OFF_STAT, 16'h0000);
      lamps(16'h0033, 32, 16, 0);
      lamps(16'h0007, 32, 32, 32);
      lamps(16'h0038, 0, 0, 0);
      lnk(1'b1, OFF_CTRL, 16'h0000);
      lnk(1'b1, OFF_MSG, 16'h0000);
      dg(4'h1);
      dg(4'h2);
      lr(OFF_DATA, 16'd12);
      kup <= 1'b1;
      lr(OFF_STAT, 16'h0400);
      lr(OFF_DATA, 16'd13);
      kup <= 1'b0;
      kdn <= 1'b1;
      lr(OFF_STAT, 16'h0800);
      lr(OFF_DATA, 16'd12);
      kdn <= 1'b0;
      ken <= 1'b1;
      lr(OFF_STAT, 16'h0220);
      ken <= 1'b0;
      lr(OFF_STAT, 16'h0020);
      lr(OFF_DATA, 16'd12);
      lnk(1'b1, OFF_CTRL, 16'h0040);
      lr(OFF_STAT, 16'h0000);
      lnk(1'b1, OFF_CTRL, 16'h0000);
      enter;
      lr(OFF_STAT, 16'h0020);
      lnk(1'b1, OFF_MSG, 16'h0005);
      lr(OFF_STAT, 16'h0000);
      lr(OFF_MSG, 16'h0005);
      lr(3'h1, 16'h0000);
      asw <= 5'h00;
      axi_wr(H_TARGET, 32'h0, RESP_OKAY);
      lr(OFF_STAT, 16'h0000);
      axi_wr(H_CTRL, 32'h1, RESP_OKAY);
      axi_wr(H_AUTO, 32'h1, RESP_OKAY);
      dg(4'h4);
      dg(4'h2);
      cyc(60);
      rdchk(H_LIVE, 32'd42);
      enter;
      cyc(60);
      axi_rd(H_STAT, RESP_OKAY);
      chk(32'(d[3:2]), 32'h2);
      rdchk(H_FINAL, 32'd42);
      chk(32'(lamp[0]), 32'h1);
      axi_rd(H_STAT, RESP_OKAY);
      chk(32'(d[3]), 32'h0);
      axi_wr(H_AUTO, 32'h0, RESP_OKAY);
      cyc(30);
      wrap_up;
   end
endmodule
